// ---- rtl/spism_core.sv ----
// spism_core: spi slave data path with normal and buffered modes, plus ss mode fault
// assumes sck/ss/mosi from an external master; controls and flags are plain ports
`timescale 1ns/100ps
module spism_core (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_sck,
   input  wire logic       i_ss_n,
   input  wire logic       i_mosi,
   output logic            o_miso,
   output logic            o_miso_oe_n,
   input  wire logic       i_enable,
   input  wire logic       i_master_set,
   output logic            o_master_role,
   input  wire logic       i_select_pin_ignore,
   input  wire logic       i_ss_is_output,
   input  wire logic       i_miso_is_output,
   input  wire logic       i_buffered_mode_on,
   input  wire logic       i_wait_receive_select,
   input  wire logic       i_irq_enable,
   input  wire logic       i_data_wr,
   input  wire logic [7:0] i_data_wdata,
   output logic      [7:0] o_rx_data,
   input  wire logic       i_flags_clr,
   output logic            o_done_flag,
   output logic            o_write_clash_flag,
   output logic            o_tx_buffer_empty_flag,
   output logic            o_receive_done_flag,
   output logic            o_transmit_done_flag,
   output logic            o_irq
);
   logic [2:0] pins_s;
   logic       sck_s, ss_n_s, mosi_s, sck_prev_q;
   logic       sck_rise, sck_fall, slave_act;
   logic [7:0] shift_q, txbuf_q;
   logic [2:0] bitcnt_q;
   logic       master_q, busy_q, txbuf_full_q, byte_end;
   logic       done_q, clash_q, dre_q, rxc_q, txc_q, dre_rise_q, rxc_rise_q;
   logic       last_byte_q;
   spism_pkg::spism_state_e state_q;

   // slave mode 0 assumed: sample on rise, shift on fall
   spism_sync #(.WIDTH(3), .RST_VAL(3'b010)) u_sync (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_async ({i_sck, i_ss_n, i_mosi}),
      .o_sync  (pins_s)
   );
   assign sck_s  = pins_s[2];
   assign ss_n_s = pins_s[1];
   assign mosi_s = pins_s[0];

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         sck_prev_q <= 1'b0;
      else
         sck_prev_q <= sck_s;
   end
   assign sck_rise  = sck_s & ~sck_prev_q;
   assign sck_fall  = ~sck_s & sck_prev_q;
   assign slave_act = i_enable & ~master_q & ~ss_n_s;
   assign byte_end  = slave_act & sck_fall & (bitcnt_q == 3'h7);

   // master role; set wins only when no fault is pending this cycle
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         master_q <= 1'b0;
      else if (i_enable & master_q & ~i_select_pin_ignore & ~i_ss_is_output & ~ss_n_s)
         master_q <= 1'b0;
      else if (i_master_set)
         master_q <= 1'b1;
   end
   assign o_master_role = master_q;

   // shift and bit counter
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         shift_q  <= spism_pkg::SHIFT_RST;
         bitcnt_q <= '0;
         busy_q   <= 1'b0;
         state_q  <= spism_pkg::SPISM_IDLE;
      end
      else if (!slave_act)
      begin
         bitcnt_q <= '0;   // partial byte dropped
         busy_q   <= 1'b0;
         state_q  <= spism_pkg::SPISM_IDLE;
         if (i_data_wr & ~i_buffered_mode_on)
            shift_q <= i_data_wdata;
         else if (i_buffered_mode_on & i_wait_receive_select & txbuf_full_q)
            shift_q <= txbuf_q;
      end
      else
      begin
         unique case (state_q)
            spism_pkg::SPISM_IDLE,
            spism_pkg::SPISM_DONE:
               if (sck_rise)
               begin
                  state_q <= spism_pkg::SPISM_SHIFT;
                  busy_q  <= 1'b1;
                  shift_q <= {shift_q[6:0], mosi_s};
               end
               else if (i_data_wr & ~i_buffered_mode_on & ~busy_q)
                  shift_q <= i_data_wdata;
            spism_pkg::SPISM_SHIFT:
               if (sck_rise)
                  shift_q <= {shift_q[6:0], mosi_s};
               else if (byte_end)
               begin
                  bitcnt_q <= '0;
                  busy_q   <= 1'b0;
                  state_q  <= spism_pkg::SPISM_DONE;
               end
               else if (sck_fall)
                  bitcnt_q <= bitcnt_q + 3'h1;
         endcase
         if (byte_end & i_buffered_mode_on & txbuf_full_q)
            shift_q <= txbuf_q;
      end
   end
   // miso: msb of the shift register, shifted data appears after each fall
   logic miso_q;
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         miso_q <= 1'b0;
      else if (!slave_act | sck_fall | (state_q != spism_pkg::SPISM_SHIFT))
         miso_q <= shift_q[7];
   end
   assign o_miso      = miso_q;
   assign o_miso_oe_n = ~(slave_act & i_miso_is_output);

   // received byte captured at end of byte
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_rx_data <= '0;
      else if (byte_end)
         o_rx_data <= shift_q;
   end

   // transmit buffer
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         txbuf_q      <= spism_pkg::BUF_RST;
         txbuf_full_q <= 1'b0;
      end
      else if (i_buffered_mode_on)
      begin
         if (i_data_wr & ~txbuf_full_q)   // a full buffer ignores the write
         begin
            txbuf_q      <= i_data_wdata;
            txbuf_full_q <= 1'b1;
         end
         else if (byte_end | (~slave_act & i_wait_receive_select))
            txbuf_full_q <= 1'b0;
      end
      else
         txbuf_full_q <= 1'b0;
   end

   // flags; hardware set wins over clear
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         done_q     <= 1'b0;
         clash_q    <= 1'b0;
         dre_q      <= 1'b1;
         rxc_q      <= 1'b0;
         txc_q      <= 1'b0;
         dre_rise_q <= 1'b0;
         rxc_rise_q <= 1'b0;
         last_byte_q <= 1'b0;
      end
      else
      begin
         if ((byte_end & ~i_buffered_mode_on) | (o_master_role & ~master_q_next()))
            done_q <= 1'b1;
         else if (i_flags_clr)
            done_q <= 1'b0;
         if (i_data_wr & ~i_buffered_mode_on & busy_q)
            clash_q <= 1'b1;
         else if (i_flags_clr)
            clash_q <= 1'b0;
         if (i_buffered_mode_on & i_data_wr & ~txbuf_full_q)
            dre_q <= 1'b0;
         else if (i_buffered_mode_on & txbuf_full_q & (byte_end | (~slave_act & i_wait_receive_select)))
            dre_q <= 1'b1;
         dre_rise_q <= i_buffered_mode_on & byte_end;
         if (dre_rise_q)
            rxc_q <= 1'b1;
         else if (i_flags_clr)
            rxc_q <= 1'b0;
         // buffer state taken at the byte end; a refill there means more to send
         last_byte_q <= i_buffered_mode_on & byte_end & ~txbuf_full_q & ~i_data_wr;
         rxc_rise_q  <= dre_rise_q & last_byte_q;
         if (rxc_rise_q)
            txc_q <= 1'b1;
         else if (i_flags_clr)
            txc_q <= 1'b0;
      end
   end
   function automatic logic master_q_next();
      master_q_next = ~(i_enable & ~i_select_pin_ignore & ~i_ss_is_output & ~ss_n_s);
   endfunction : master_q_next

   assign o_done_flag            = done_q;
   assign o_write_clash_flag     = clash_q;
   assign o_tx_buffer_empty_flag = dre_q;
   assign o_receive_done_flag    = rxc_q;
   assign o_transmit_done_flag   = txc_q;
   assign o_irq                  = i_irq_enable & done_q;

   a_fault_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_enable & master_q & ~i_select_pin_ignore & ~i_ss_is_output & ~ss_n_s) |=> !master_q)
      else $error("master role not cleared by ss low");
   a_fault_done: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $fell(master_q) |-> done_q)
      else $error("done flag missing after mode fault");
   a_ignore_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (master_q & i_select_pin_ignore & ~i_master_set) |=> master_q)
      else $error("ss affected master with ignore set");
   a_ss_output: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (master_q & i_ss_is_output) |=> master_q)
      else $error("ss output level dropped master");
   a_idle_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ss_n_s |=> (bitcnt_q == 3'h0) && !busy_q)
      else $error("slave active while deselected");
   a_clash_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_data_wr & ~i_buffered_mode_on & busy_q & ~sck_rise) |=> clash_q && $stable(shift_q))
      else $error("collision not flagged");
   a_full_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_buffered_mode_on & i_data_wr & txbuf_full_q) |=> $stable(txbuf_q))
      else $error("full buffer overwritten");
   a_rxc_after: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      dre_rise_q |=> rxc_q)
      else $error("receive flag late");
   a_txc_after: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      rxc_rise_q |=> txc_q)
      else $error("transmit flag late");
   a_miso_tri: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ss_n_s |-> o_miso_oe_n)
      else $error("miso driven while deselected");
endmodule : spism_core

// ---- rtl/spism_pkg.sv ----
// spism_pkg: shared constants for the spi slave and mode-fault block
// assumes a single peripheral clock; no register bus, all controls are ports
package spism_pkg;
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned BIT_CNT_W = 3;
   localparam logic [7:0]  SHIFT_RST = 8'h00;
   localparam logic [7:0]  BUF_RST   = 8'h00;
   localparam int unsigned SYNC_STAGES = 2;
   // minimum sck phase the master must keep, in peripheral clock cycles
   localparam int unsigned SCK_MIN_PHASE_CYC = 2;
   typedef enum logic [1:0] {SPISM_IDLE, SPISM_SHIFT, SPISM_DONE} spism_state_e;
endpackage : spism_pkg

// ---- rtl/spism_sync.sv ----
// spism_sync: two-flop synchroniser for pins entering the peripheral clock
// assumes input is asynchronous to i_mclk
`timescale 1ns/100ps
module spism_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         meta_q <= RST_VAL;
         o_sync <= RST_VAL;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : spism_sync

// ---- tb/spism_master_model.sv ----
// spism_master_model: behavioural spi master, mode 0, msb first
// assumes the slave samples sck with a much faster peripheral clock
`timescale 1ns/100ps
module spism_master_model (
   output logic      o_sck,
   output logic      o_ss_n,
   output logic      o_mosi,
   input  wire logic i_miso
);
   localparam realtime HALF = 62.5; // each sck phase well over two mclk cycles
   initial
   begin
      o_sck  = 1'b0;
      o_ss_n = 1'b1;
      o_mosi = 1'b0;
   end
   // released mosi shows the inverse, so no stale bit can pass for data
   task automatic sel(input logic v);
      #1;
      o_ss_n = v;
      if (v) o_mosi = ~o_mosi;
   endtask : sel
   // sck stands still outside frames
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      sel(1'b0);
      #(2*HALF);
      for (int i = 0; i < nb; i++)
      begin
         o_mosi = tx[7-i];
         #HALF o_sck = 1'b1;
         rx = {rx[6:0], i_miso};
         #HALF o_sck = 1'b0;
      end
      #(2*HALF);
      sel(1'b1);
   endtask : xfer
endmodule : spism_master_model

// ---- tb/tb.sv ----
// tb: self-checking bench for spism_core against a behavioural master
// assumes mode 0 master, 100 MHz peripheral clock, 125 ns sck
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
   logic       i_mclk, i_rst_n, i_master_set, i_select_pin_ignore, i_ss_is_output;
   logic       i_buffered_mode_on, i_data_wr, i_flags_clr, sck, ss_n, mosi;
   logic       i_irq_enable, i_wait_receive_select;
   logic [7:0] i_data_wdata, o_rx_data, got, m1, m2, exp;
   logic       o_miso, o_miso_oe_n, o_master_role, o_done_flag, o_write_clash_flag;
   logic       o_tx_buffer_empty_flag, o_receive_done_flag, o_transmit_done_flag, o_irq;
   logic       done_d, rxd_d, emp_d;
   logic [7:0] q[$];
   int         num_errors, check_count, cyc;
   spism_core dut (.i_mclk, .i_rst_n, .i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi), .o_miso,
      .o_miso_oe_n, .i_enable(1'b1), .i_master_set, .o_master_role, .i_select_pin_ignore,
      .i_ss_is_output, .i_miso_is_output(1'b1), .i_buffered_mode_on,
      .i_wait_receive_select, .i_irq_enable, .i_data_wr, .i_data_wdata,
      .o_rx_data, .i_flags_clr, .o_done_flag, .o_write_clash_flag, .o_tx_buffer_empty_flag,
      .o_receive_done_flag, .o_transmit_done_flag, .o_irq);
   spism_master_model m (.o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi), .i_miso(o_miso));
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] b);
      @(posedge i_mclk);
      i_data_wr    <= 1'b1;
      i_data_wdata <= b;
      @(posedge i_mclk);
      i_data_wr    <= 1'b0;
   endtask : wr
   // flags are sticky, so clear before each transfer to see fresh edges
   task automatic clr();
      @(posedge i_mclk);
      i_flags_clr <= 1'b1;
      @(posedge i_mclk);
      i_flags_clr <= 1'b0;
      repeat (2) @(posedge i_mclk);
   endtask : clr
   task automatic go(input logic [7:0] tx);
      clr();
      q.push_back(tx);
      m.xfer(tx, 8, got);
      repeat (10) @(posedge i_mclk);
   endtask : go
   // monitor: each new byte-end flag takes the oldest expected rx byte
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         close_out();
      end
      if (i_rst_n && ((o_done_flag && !done_d) || (o_receive_done_flag && !rxd_d)))
      begin
         if (q.size() > 0)
         begin
            exp = q.pop_front();
            `CHK("rx_data", exp, o_rx_data)
         end
         if (o_receive_done_flag && !rxd_d) `CHK("empty_before_rx", 1'b1, emp_d)
      end
      done_d <= o_done_flag;
      rxd_d  <= o_receive_done_flag;
      emp_d  <= o_tx_buffer_empty_flag;
   end
   initial
   begin
      {i_rst_n, i_master_set, i_select_pin_ignore, i_ss_is_output} = 4'h0;
      {i_buffered_mode_on, i_data_wr, i_flags_clr, i_data_wdata} = 11'h000;
      {i_irq_enable, i_wait_receive_select} = 2'b10;
      num_errors  = 0;
      check_count = 0;
      cyc         = 0;
      void'($urandom(32'h9a08));
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
      `CHK("empty_rst", 1'b1, o_tx_buffer_empty_flag)
      `CHK("oe_rst", 1'b1, o_miso_oe_n)
      wr(8'ha5);
      m1 = 8'($urandom);
      clr();
      q.push_back(m1);
      fork
         m.xfer(m1, 8, got);
         begin
            #500;
            `CHK("oe_sel", 1'b0, o_miso_oe_n)
            wr(8'h3c);
         end
      join
      repeat (10) @(posedge i_mclk);
      `CHK("tx_normal", 8'ha5, got)
      `CHK("clash", 1'b1, o_write_clash_flag)
      `CHK("oe_idle", 1'b1, o_miso_oe_n)
      m2 = 8'($urandom);
      go(m2);
      `CHK("dropped_write", m1, got)
      $display("test normal done");
      @(posedge i_mclk);
      i_buffered_mode_on <= 1'b1;
      wr(8'h43);
      @(posedge i_mclk);
      `CHK("empty_wr", 1'b0, o_tx_buffer_empty_flag)
      go(8'h11);
      `CHK("dummy", m2, got)
      `CHK("empty_copy", 1'b1, o_tx_buffer_empty_flag)
      wr(8'h44);
      wr(8'h45);
      go(8'h22);
      `CHK("buf_first", 8'h43, got)
      `CHK("txc_pending", 1'b0, o_transmit_done_flag)
      go(8'h33);
      `CHK("buf_full_drop", 8'h44, got)
      `CHK("txc", 1'b1, o_transmit_done_flag)
      $display("test buffered done");
      @(posedge i_mclk);
      i_buffered_mode_on <= 1'b0;
      clr();
      m.xfer(8'h5a, 4, got);
      repeat (10) @(posedge i_mclk);
      `CHK("partial", 1'b0, o_done_flag)
      `CHK("partial_rx", 8'h33, o_rx_data)
      m1 = 8'($urandom);
      go(m1); // bit counter restarts after a cut frame
      $display("test partial done");
      i_ss_is_output     <= 1'b1;
      i_master_set       <= 1'b1;
      @(posedge i_mclk);
      i_master_set <= 1'b0;
      m.sel(1'b0);
      repeat (10) @(posedge i_mclk);
      `CHK("ss_output", 1'b1, o_master_role)
      i_ss_is_output      <= 1'b0;
      i_select_pin_ignore <= 1'b1;
      repeat (10) @(posedge i_mclk);
      `CHK("ss_ignored", 1'b1, o_master_role)
      clr();
      i_select_pin_ignore <= 1'b0;
      repeat (10) @(posedge i_mclk);
      `CHK("mode_fault", 1'b0, o_master_role)
      `CHK("fault_flag", 1'b1, o_done_flag)
      `CHK("fault_irq", 1'b1, o_irq)
      i_irq_enable <= 1'b0;
      repeat (2) @(posedge i_mclk);
      `CHK("irq_masked", 1'b0, o_irq)
      m.sel(1'b1);
      `CHK("queue_empty", 0, q.size())
      $display("test mode fault done");
      close_out();
   end
endmodule : tb
